// *** src/epm_defines.svh ***
`ifndef EPM_DEFINES_SVH
`define EPM_DEFINES_SVH

`define EPM_AMP_W 11
`define EPM_ANGLE_W 10
`define EPM_MCC_W 14
`define EPM_POS_W 24
`define EPM_RES_W 10
`define EPM_LED_W 8
`define EPM_BW_W 3
// Fixed amplitude window in pin mode, in percent of the calibrated value.
`define EPM_PIN_LO_PCT 60
`define EPM_PIN_HI_PCT 120
`define EPM_PCT_DEN 100
// Counter is flagged as nearly full this many cycles before either limit.
`define EPM_MCC_MARGIN 14'h0010
`define EPM_MCC_RST 14'h0000
`define EPM_LED_RST 8'h80
`define EPM_BW_RST 3'h4
`define EPM_BW_MAX 3'h7
// Store is 8 words of 8 data bits; word 7 holds the checksum.
`define EPM_NV_WORDS 8
`define EPM_NV_AW 3
`define EPM_NV_CW 13
`define EPM_USER_BASE 3'h3
`define EPM_CSUM_ADDR 3'h7

`endif

// *** src/epm_pkg.sv ***
package epm_pkg;
	typedef struct packed {
		logic [13:0] mcc;
		logic [9:0] angle;
	} epm_position_t;
	typedef struct packed {
		logic signed [9:0] offset;
		logic signed [9:0] balance;
		logic signed [9:0] phase;
	} epm_residual_t;
	typedef struct packed {
		logic amp_fault;
		logic residual_fault;
		logic overflow_warn;
		logic capture_event;
	} epm_fault_t;
	typedef enum logic [1:0] {
		EPM_NV_IDLE,
		EPM_NV_LOAD,
		EPM_NV_CHECK,
		EPM_NV_READY
	} epm_nv_state_t;
endpackage

// *** src/epm_nv_mem.sv ***
`timescale 1ns/100ps
`include "epm_defines.svh"

// Hamming-coded word store; read data is registered, single errors corrected.
module epm_nv_mem #(
	parameter int WORDS = `EPM_NV_WORDS,
	parameter int AW = `EPM_NV_AW
) (
	input wire logic mclk_in,
	input wire logic we_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	output logic sec_out,
	output logic ded_out
);
	logic [12:0] mem_q [WORDS];
	logic [7:0] rdata_q;
	logic sec_q;
	logic ded_q;
	logic [12:0] code_w;
	logic [12:0] rd_w;
	logic [12:0] fix_w;
	logic [3:0] syn_w;
	logic par_w;

	// Positions 1..12 Hamming, bit 0 overall parity (SEC-DED).
	function automatic logic [12:0] enc(input logic [7:0] d);
		logic [12:0] c;
		c = 13'h0000;
		{c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]} = d;
		c[1] = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
		c[2] = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
		c[4] = c[5] ^ c[6] ^ c[7] ^ c[12];
		c[8] = c[9] ^ c[10] ^ c[11] ^ c[12];
		c[0] = ^c[12:1];
		return c;
	endfunction

	assign code_w = enc(wdata_in);
	assign rd_w = mem_q[addr_in];
	assign syn_w = {rd_w[8] ^ rd_w[9] ^ rd_w[10] ^ rd_w[11] ^ rd_w[12],
		rd_w[4] ^ rd_w[5] ^ rd_w[6] ^ rd_w[7] ^ rd_w[12],
		rd_w[2] ^ rd_w[3] ^ rd_w[6] ^ rd_w[7] ^ rd_w[10] ^ rd_w[11],
		rd_w[1] ^ rd_w[3] ^ rd_w[5] ^ rd_w[7] ^ rd_w[9] ^ rd_w[11]};
	assign par_w = ^rd_w;
	assign fix_w = (par_w && syn_w != 4'h0 && syn_w < 4'hD) ? (rd_w ^ (13'h0001 << syn_w)) : rd_w;

	always_ff @(posedge mclk_in) begin
		if (we_in) begin
			mem_q[addr_in] <= code_w;
		end
		rdata_q <= {fix_w[12], fix_w[11], fix_w[10], fix_w[9], fix_w[7], fix_w[6], fix_w[5], fix_w[3]};
		sec_q <= par_w;
		ded_q <= !par_w && syn_w != 4'h0;
	end

	assign rdata_out = rdata_q;
	assign sec_out = sec_q;
	assign ded_out = ded_q;
endmodule

// *** src/epm_monitor.sv ***
`timescale 1ns/100ps
`include "epm_defines.svh"

module epm_monitor (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic signed [9:0] sin_in,
	input wire logic signed [9:0] cos_in,
	input wire logic [9:0] angle_in,
	input wire logic index_out_in,
	input wire logic gate_window_in,
	input wire logic signed [9:0] acceleration_in,
	input wire logic config_mode_select_in,
	input wire logic calibrate_request_n_in,
	input wire logic zero_pos_in,
	input wire logic zero_neg_in,
	input wire logic [10:0] amp_cal_in,
	input wire logic [10:0] amp_lo_in,
	input wire logic [10:0] amp_hi_in,
	input wire logic led_ctrl_en_in,
	input wire logic mcc_clr_on_index_in,
	input wire logic mcc_load_in,
	input wire logic [13:0] mcc_load_val_in,
	input wire logic mcc_ovf_irq_en_in,
	input wire logic capture_sel_gate_in,
	input wire logic capture_irq_en_in,
	input wire logic adapt_en_in,
	input wire logic [9:0] res_thresh_in,
	input wire logic driver_disable_in,
	input wire logic nv_unlock_in,
	input wire logic nv_lock_in,
	input wire logic nv_we_in,
	input wire logic [2:0] nv_addr_in,
	input wire logic [7:0] nv_wdata_in,
	output logic [10:0] amplitude_out,
	output logic [7:0] led_level_out,
	output logic [13:0] mcc_spi_out,
	output logic [13:0] mcc_field_link_out,
	output epm_pkg::epm_position_t capture_out,
	output logic [2:0] filter_bw_out,
	output epm_pkg::epm_residual_t residual_out,
	output epm_pkg::epm_fault_t fault_status_out,
	output logic fault_request_n_out,
	output logic [7:0] nv_rdata_out,
	output logic nv_unlocked_out,
	output logic nv_ready_out,
	output logic nv_error_out,
	output logic calibrate_start_out,
	output logic index_pulse_en_out,
	output logic index_enable_out,
	output logic driver_enable_out,
	output logic pin_mode_out
);
	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers for pins.
	logic [1:0] mode_s_q;
	logic [1:0] cal_s_q;
	logic [1:0] zp_s_q;
	logic [1:0] zn_s_q;
	logic pin_mode_w;
	logic cal_low_w;

	always_ff @(posedge mclk_in) begin
		mode_s_q <= {mode_s_q[0], config_mode_select_in};
		cal_s_q <= {cal_s_q[0], calibrate_request_n_in};
		zp_s_q <= {zp_s_q[0], zero_pos_in};
		zn_s_q <= {zn_s_q[0], zero_neg_in};
	end

	assign pin_mode_w = mode_s_q[1];
	assign cal_low_w = !cal_s_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Amplitude: squared magnitude, then a bit-serial square root.
	logic [20:0] sumsq_w;
	logic [21:0] rad_q;
	logic [21:0] rem_q;
	logic [10:0] root_q;
	logic [3:0] step_q;
	logic [10:0] amp_q;
	logic [21:0] trial_w;
	logic [21:0] rem_sh_w;

	assign sumsq_w = 21'(sin_in * sin_in) + 21'(cos_in * cos_in);
	assign rem_sh_w = {rem_q[19:0], rad_q[21:20]};
	assign trial_w = {9'h000, root_q, 2'h1};

	// Restoring root, one result bit per clock; amplitude refreshes every 12 clocks.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			step_q <= 4'h0;
			rem_q <= 22'h000000;
			root_q <= 11'h000;
			rad_q <= 22'h000000;
			amp_q <= 11'h000;
		end else if (step_q == 4'h0) begin
			// Radicand padded to an even bit count so each step takes a true digit pair.
			rad_q <= {1'b0, sumsq_w};
			rem_q <= 22'h000000;
			root_q <= 11'h000;
			step_q <= 4'h1;
		end else begin
			rad_q <= {rad_q[19:0], 2'h0};
			if (rem_sh_w >= trial_w) begin
				rem_q <= rem_sh_w - trial_w;
				root_q <= {root_q[9:0], 1'b1};
			end else begin
				rem_q <= rem_sh_w;
				root_q <= {root_q[9:0], 1'b0};
			end
			if (step_q == 4'hB) begin
				step_q <= 4'h0;
				amp_q <= (rem_sh_w >= trial_w) ? {root_q[9:0], 1'b1} : {root_q[9:0], 1'b0};
			end else begin
				step_q <= step_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Amplitude window and LED regulation.
	logic [17:0] amp_pct_w;
	logic [17:0] lo_pin_w;
	logic [17:0] hi_pin_w;
	logic amp_fault_w;
	logic [7:0] led_q;

	assign amp_pct_w = 18'(amp_q) * 18'(`EPM_PCT_DEN);
	assign lo_pin_w = 18'(amp_cal_in) * 18'(`EPM_PIN_LO_PCT);
	assign hi_pin_w = 18'(amp_cal_in) * 18'(`EPM_PIN_HI_PCT);
	assign amp_fault_w = pin_mode_w ? (amp_pct_w < lo_pin_w || amp_pct_w > hi_pin_w)
		: (amp_q < amp_lo_in || amp_q > amp_hi_in);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			led_q <= `EPM_LED_RST;
		end else if (!pin_mode_w && led_ctrl_en_in && step_q == 4'h0) begin
			if (amp_q < amp_cal_in && led_q != 8'hFF) begin
				led_q <= led_q + 8'h01;
			end else if (amp_q > amp_cal_in && led_q != 8'h00) begin
				led_q <= led_q - 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Multi-cycle counter and capture.
	logic [9:0] angle_q;
	logic idx_q;
	logic gate_q;
	logic cyc_up_w;
	logic cyc_dn_w;
	logic idx_rise_w;
	logic cap_trig_w;
	logic [13:0] mcc_q;
	logic [13:0] mcc_d;
	epm_pkg::epm_position_t cap_q;
	logic cap_evt_q;

	always_ff @(posedge mclk_in) begin
		angle_q <= angle_in;
		idx_q <= index_out_in;
		gate_q <= gate_window_in;
	end

	// Wrap of the top two angle bits marks a completed cycle in either direction.
	assign cyc_up_w = angle_q[9:8] == 2'h3 && angle_in[9:8] == 2'h0;
	assign cyc_dn_w = angle_q[9:8] == 2'h0 && angle_in[9:8] == 2'h3;
	assign idx_rise_w = index_out_in && !idx_q;
	assign cap_trig_w = capture_sel_gate_in ? (gate_window_in && !gate_q) : idx_rise_w;

	always_comb begin
		mcc_d = mcc_q;
		if (cyc_up_w) begin
			mcc_d = mcc_q + 14'h0001;
		end else if (cyc_dn_w) begin
			mcc_d = mcc_q - 14'h0001;
		end
		if (mcc_clr_on_index_in && idx_rise_w) begin
			mcc_d = `EPM_MCC_RST;
		end
		if (!pin_mode_w && mcc_load_in) begin
			mcc_d = mcc_load_val_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mcc_q <= `EPM_MCC_RST;
			cap_q <= '0;
			cap_evt_q <= 1'b0;
		end else begin
			mcc_q <= mcc_d;
			cap_evt_q <= cap_trig_w && !pin_mode_w;
			if (cap_trig_w && !pin_mode_w) begin
				cap_q <= {mcc_q, angle_in};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Filter adaption and residual errors.
	logic [2:0] bw_q;
	logic [2:0] bw_adapt_w;
	logic [9:0] acc_mag_w;
	epm_pkg::epm_residual_t res_q;
	logic [9:0] off_abs_w;
	logic [9:0] bal_abs_w;
	logic [9:0] ph_abs_w;
	logic res_fault_w;

	assign acc_mag_w = acceleration_in[9] ? 10'(-acceleration_in) : acceleration_in;
	// Harder acceleration opens the bandwidth so the path follows fast; full scale saturates at the widest.
	assign bw_adapt_w = acc_mag_w[9] ? `EPM_BW_MAX : `EPM_BW_RST + {1'b0, acc_mag_w[8:7]};

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			bw_q <= `EPM_BW_RST;
		end else if (!pin_mode_w && adapt_en_in) begin
			bw_q <= bw_adapt_w;
		end else begin
			bw_q <= `EPM_BW_RST;
		end
	end

	// Offset from the sum, balance from magnitude difference, phase from the product sign bias.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			res_q <= '0;
		end else begin
			res_q.offset <= 10'((11'(sin_in) + 11'(cos_in)) >>> 1);
			res_q.balance <= 10'((11'(sin_in[9] ? -sin_in : sin_in) - 11'(cos_in[9] ? -cos_in : cos_in)) >>> 1);
			res_q.phase <= 10'(21'(sin_in * cos_in) >>> 9);
		end
	end

	assign off_abs_w = res_q.offset[9] ? 10'(-res_q.offset) : res_q.offset;
	assign bal_abs_w = res_q.balance[9] ? 10'(-res_q.balance) : res_q.balance;
	assign ph_abs_w = res_q.phase[9] ? 10'(-res_q.phase) : res_q.phase;
	assign res_fault_w = off_abs_w > res_thresh_in || bal_abs_w > res_thresh_in || ph_abs_w > res_thresh_in;

	////////////////////////////////////////////////////////////////////////////
	// Protected store: unlock, startup load and checksum.
	epm_pkg::epm_nv_state_t nv_st_q;
	logic unlocked_q;
	logic [2:0] ld_addr_q;
	logic [7:0] csum_q;
	logic nv_err_q;
	logic [2:0] mem_addr_w;
	logic mem_we_w;
	logic [7:0] mem_rd_w;
	logic mem_ded_w;

	assign mem_we_w = nv_we_in && unlocked_q && nv_st_q == epm_pkg::EPM_NV_READY;
	assign mem_addr_w = (nv_st_q == epm_pkg::EPM_NV_READY) ? nv_addr_in : ld_addr_q;

	epm_nv_mem u_mem (
		.mclk_in(mclk_in),
		.we_in(mem_we_w),
		.addr_in(mem_addr_w),
		.wdata_in(nv_wdata_in),
		.rdata_out(mem_rd_w),
		.sec_out(),
		.ded_out(mem_ded_w)
	);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			nv_st_q <= epm_pkg::EPM_NV_IDLE;
			unlocked_q <= 1'b0;
			ld_addr_q <= 3'h0;
			csum_q <= 8'h00;
			nv_err_q <= 1'b0;
		end else begin
			if (nv_unlock_in && !pin_mode_w) begin
				unlocked_q <= 1'b1;
			end else if (nv_lock_in) begin
				unlocked_q <= 1'b0;
			end
			unique case (nv_st_q)
				epm_pkg::EPM_NV_IDLE: nv_st_q <= epm_pkg::EPM_NV_LOAD;
				epm_pkg::EPM_NV_LOAD: begin
					// Read data trail the address by one clock.
					ld_addr_q <= ld_addr_q + 3'h1;
					nv_st_q <= epm_pkg::EPM_NV_CHECK;
				end
				epm_pkg::EPM_NV_CHECK: begin
					csum_q <= csum_q + mem_rd_w;
					nv_err_q <= nv_err_q | mem_ded_w;
					if (ld_addr_q == 3'h0) begin
						nv_st_q <= epm_pkg::EPM_NV_READY;
					end else begin
						ld_addr_q <= ld_addr_q + 3'h1;
					end
				end
				epm_pkg::EPM_NV_READY: begin
					// Words 0..6 plus checksum word must sum to zero.
					if (csum_q != 8'h00) begin
						nv_err_q <= 1'b1;
						csum_q <= 8'h00;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Calibration start, index strapping and fault request.
	logic cal_q;
	logic cal_start_q;
	logic cal_boot_q;
	logic ovf_near_w;
	epm_pkg::epm_fault_t flt_w;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cal_q <= 1'b0;
			cal_start_q <= 1'b0;
			cal_boot_q <= 1'b1;
		end else begin
			cal_q <= cal_low_w;
			cal_boot_q <= 1'b0;
			// In pin mode only, the boot slot catches a strap held low since power-up.
			cal_start_q <= (cal_low_w && !cal_q && !cal_boot_q)
				|| (cal_boot_q && pin_mode_w && cal_low_w);
		end
	end

	assign ovf_near_w = mcc_q >= (14'h3FFF - `EPM_MCC_MARGIN) || mcc_q <= `EPM_MCC_MARGIN;
	assign flt_w.amp_fault = amp_fault_w;
	assign flt_w.residual_fault = res_fault_w;
	assign flt_w.overflow_warn = ovf_near_w && mcc_ovf_irq_en_in && !pin_mode_w;
	assign flt_w.capture_event = cap_evt_q && capture_irq_en_in;

	assign fault_request_n_out = !(|flt_w);
	assign fault_status_out = flt_w;
	assign amplitude_out = amp_q;
	assign led_level_out = pin_mode_w ? `EPM_LED_RST : led_q;
	assign mcc_spi_out = mcc_q;
	assign mcc_field_link_out = 14'h0000;
	assign capture_out = cap_q;
	assign filter_bw_out = bw_q;
	assign residual_out = res_q;
	assign nv_rdata_out = mem_rd_w;
	assign nv_unlocked_out = unlocked_q;
	assign nv_ready_out = nv_st_q == epm_pkg::EPM_NV_READY;
	assign nv_error_out = nv_err_q;
	assign calibrate_start_out = cal_start_q;
	assign index_pulse_en_out = zp_s_q[1] && !zn_s_q[1];
	assign index_enable_out = !(!zp_s_q[1] && zn_s_q[1]);
	assign driver_enable_out = pin_mode_w || !driver_disable_in;
	assign pin_mode_out = pin_mode_w;

	////////////////////////////////////////////////////////////////////////////
	amp_window_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		pin_mode_w && amp_pct_w < lo_pin_w |-> !fault_request_n_out)
		else $error("amplitude below window without fault");
	mcc_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		cyc_up_w && !mcc_load_in && !(mcc_clr_on_index_in && idx_rise_w) |=> mcc_q == $past(mcc_q) + 14'h0001)
		else $error("counter did not step up");
	mcc_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		mcc_clr_on_index_in && idx_rise_w && !mcc_load_in |=> mcc_q == 14'h0000)
		else $error("counter not cleared on index");
	cap_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		!cap_trig_w |=> $stable(cap_q))
		else $error("capture changed without trigger");
	nv_protect_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		!unlocked_q |-> !mem_we_w)
		else $error("store written while locked");
	field_link_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		mcc_field_link_out == 14'h0000)
		else $error("counter exposed on field link");
	cap_irq_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		cap_trig_w && !pin_mode_w && capture_irq_en_in |=> !fault_request_n_out)
		else $error("capture did not raise fault");
	amp_refresh_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		step_q == 4'h0 |-> ##12 step_q == 4'h0)
		else $error("amplitude refresh period wrong");
	drv_disable_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		!pin_mode_w && driver_disable_in |-> !driver_enable_out)
		else $error("driver not disabled");
endmodule

// *** testbench/epm_sensor_model.sv ***
`timescale 1ns/100ps
// Sensor side: a flat sin/cos vector of a set amplitude and an angle that turns on request.
module epm_sensor_model (
	input wire logic mclk_in,
	input wire logic run_in,
	input wire logic up_in,
	input wire logic [9:0] amp_in,
	output logic signed [9:0] sin_out,
	output logic signed [9:0] cos_out,
	output logic [9:0] angle_out
);
	initial angle_out = 10'h000;
	// Sixteen steps a clock make one input cycle every 64 clocks, so whole turns return to the same angle.
	always @(posedge mclk_in) begin
		if (run_in) begin
			angle_out <= up_in ? angle_out + 10'h010 : angle_out - 10'h010;
		end
	end
	assign sin_out = 10'sh000;
	assign cos_out = amp_in;
endmodule

// *** testbench/encoder_position_monitor_tb.sv ***
`timescale 1ns/100ps
module encoder_position_monitor_tb;
	logic clk = 1'b0, rst = 1'b1, run = 1'b0, up = 1'b1, idx = 1'b0, gate = 1'b0, pin = 1'b0;
	logic cal_n = 1'b1, zp = 1'b1, zn = 1'b0, led_en = 1'b0, clr_idx = 1'b0, ld = 1'b0, ovf_en = 1'b0;
	logic sel_gate = 1'b0, cap_en = 1'b0, adapt = 1'b0, drv_dis = 1'b0, unlock = 1'b0, lock = 1'b0;
	logic we = 1'b0, seen;
	logic [9:0] amp = 10'h12C, accel = 10'h000, thr = 10'h3FF;
	logic [10:0] cal = 11'h190, lo = 11'h12C, hi = 11'h1F4, amp_o;
	logic [13:0] ld_val = 14'h0000, mcc, mcc_fl;
	logic [2:0] addr = 3'h0, bw;
	logic [7:0] wdata = 8'h00, led, nv_rd;
	logic signed [9:0] sin_w, cos_w;
	logic [9:0] ang_w;
	epm_pkg::epm_position_t cap;
	epm_pkg::epm_fault_t fst;
	epm_pkg::epm_residual_t res;
	logic irq_n, unl, rdy, nerr, cal_go, idx_en, idx_on, drv_en, pin_m;
	int errors = 0, check_count = 0, cal_seen = 0;

	initial forever #12.5 clk = ~clk;
	always @(negedge clk) if (cal_go === 1'b1) cal_seen++;

	epm_sensor_model sensor (.mclk_in(clk), .run_in(run), .up_in(up), .amp_in(amp),
		.sin_out(sin_w), .cos_out(cos_w), .angle_out(ang_w));

	epm_monitor dut (.mclk_in(clk), .rst_in(rst), .sin_in(sin_w), .cos_in(cos_w), .angle_in(ang_w),
		.index_out_in(idx), .gate_window_in(gate), .acceleration_in(accel), .config_mode_select_in(pin),
		.calibrate_request_n_in(cal_n), .zero_pos_in(zp), .zero_neg_in(zn), .amp_cal_in(cal),
		.amp_lo_in(lo), .amp_hi_in(hi), .led_ctrl_en_in(led_en), .mcc_clr_on_index_in(clr_idx),
		.mcc_load_in(ld), .mcc_load_val_in(ld_val), .mcc_ovf_irq_en_in(ovf_en),
		.capture_sel_gate_in(sel_gate), .capture_irq_en_in(cap_en), .adapt_en_in(adapt),
		.res_thresh_in(thr), .driver_disable_in(drv_dis), .nv_unlock_in(unlock), .nv_lock_in(lock),
		.nv_we_in(we), .nv_addr_in(addr), .nv_wdata_in(wdata), .amplitude_out(amp_o),
		.led_level_out(led), .mcc_spi_out(mcc), .mcc_field_link_out(mcc_fl), .capture_out(cap),
		.filter_bw_out(bw), .residual_out(res), .fault_status_out(fst), .fault_request_n_out(irq_n),
		.nv_rdata_out(nv_rd), .nv_unlocked_out(unl), .nv_ready_out(rdy), .nv_error_out(nerr),
		.calibrate_start_out(cal_go), .index_pulse_en_out(idx_en), .index_enable_out(idx_on),
		.driver_enable_out(drv_en), .pin_mode_out(pin_m));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_true(input logic ok);
		check_val({23'h000000, ok}, 24'h000001);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Thirty cycles after release leave room for the store load to finish.
	task automatic do_reset;
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		cyc(30);
	endtask
	task automatic load_mcc(input logic [13:0] v);
		ld_val = v;
		ld = 1'b1;
		cyc(1);
		ld = 1'b0;
		cyc(1);
	endtask
	task automatic rotate(input logic u, input int n);
		up = u;
		run = 1'b1;
		cyc(64 * n);
		run = 1'b0;
		cyc(4);
	endtask
	task automatic nv_write(input logic [2:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		we = 1'b1;
		cyc(1);
		we = 1'b0;
		cyc(1);
	endtask
	task automatic nv_read(input logic [2:0] a, input logic [7:0] exp);
		addr = a;
		cyc(2);
		check_val(nv_rd, exp);
	endtask
	task automatic nv_key(input logic open);
		unlock = open;
		lock = ~open;
		cyc(1);
		unlock = 1'b0;
		lock = 1'b0;
		cyc(1);
	endtask
	task automatic conclude;
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		errors++;
		conclude;
	end

	initial begin
		cyc(1);
		do_reset;
		check_val(mcc, 14'h0000);
		check_val(cap, 24'h000000);
		check_val(mcc_fl, 14'h0000);
		check_val(unl, 1'b0);
		drv_dis = 1'b1;
		cyc(4);
		check_val(pin_m, 1'b0);
		check_val(drv_en, 1'b0);
		check_val(idx_en, 1'b1);
		check_val(idx_on, 1'b1);
		pin = 1'b1;
		zp = 1'b0;
		zn = 1'b1;
		cyc(4);
		check_val(pin_m, 1'b1);
		check_val(drv_en, 1'b1);
		check_val(idx_en, 1'b0);
		check_val(idx_on, 1'b0);
		$display("test straps done");
		cyc(40);
		check_val(amp_o, 11'h12C);
		check_val(irq_n, 1'b1);
		amp = 10'h0C8;
		cyc(40);
		check_val(irq_n, 1'b0);
		check_val(fst.amp_fault, 1'b1);
		amp = 10'h1F4;
		cyc(40);
		check_val(irq_n, 1'b0);
		check_val(led, 8'h80);
		load_mcc(14'h1234);
		check_val(mcc, 14'h0000);
		pin = 1'b0;
		amp = 10'h0FA;
		cyc(40);
		check_val(irq_n, 1'b0);
		amp = 10'h15E;
		cyc(40);
		check_val(irq_n, 1'b1);
		thr = 10'h010;
		cyc(2);
		check_val(res.phase, 10'h000);
		check_val(res.offset, 10'h0AF);
		check_val(fst.residual_fault, 1'b1);
		check_val(irq_n, 1'b0);
		thr = 10'h3FF;
		cyc(2);
		check_val(irq_n, 1'b1);
		$display("test amplitude done");
		load_mcc(14'h3FFE);
		check_val(mcc, 14'h3FFE);
		rotate(1'b1, 3);
		check_val(mcc, 14'h0001);
		rotate(1'b0, 2);
		check_val(mcc, 14'h3FFF);
		ovf_en = 1'b1;
		cyc(3);
		check_val(irq_n, 1'b0);
		check_val(fst.overflow_warn, 1'b1);
		load_mcc(14'h2000);
		cyc(2);
		check_val(irq_n, 1'b1);
		ovf_en = 1'b0;
		clr_idx = 1'b1;
		idx = 1'b1;
		cyc(3);
		idx = 1'b0;
		clr_idx = 1'b0;
		check_val(mcc, 14'h0000);
		$display("test counter done");
		load_mcc(14'h0ABC);
		up = 1'b1;
		run = 1'b1;
		cyc(5);
		run = 1'b0;
		sel_gate = 1'b1;
		cap_en = 1'b1;
		seen = 1'b0;
		gate = 1'b1;
		repeat (4) begin
			cyc(1);
			if (irq_n === 1'b0) seen = 1'b1;
		end
		check_true(seen);
		check_val(cap, {14'h0ABC, 10'h050});
		gate = 1'b0;
		cap_en = 1'b0;
		load_mcc(14'h0123);
		idx = 1'b1;
		cyc(3);
		idx = 1'b0;
		check_val(cap, {14'h0ABC, 10'h050});
		sel_gate = 1'b0;
		cyc(2);
		idx = 1'b1;
		cyc(3);
		idx = 1'b0;
		check_val(cap, {14'h0123, 10'h050});
		$display("test capture done");
		led_en = 1'b1;
		amp = 10'h0FA;
		adapt = 1'b1;
		accel = 10'h1FF;
		cyc(120);
		check_true(led > 8'h80);
		check_val(bw, 3'h7);
		adapt = 1'b0;
		cyc(2);
		check_val(bw, 3'h4);
		$display("test led and filter done");
		cal_n = 1'b0;
		cyc(2);
		cal_n = 1'b1;
		cyc(8);
		check_val(cal_seen, 24'h000001);
		pin = 1'b1;
		cal_n = 1'b0;
		do_reset;
		check_val(cal_seen, 24'h000002);
		cal_n = 1'b1;
		pin = 1'b0;
		cyc(4);
		$display("test calibrate done");
		nv_key(1'b1);
		check_val(unl, 1'b1);
		for (int i = 0; i < 7; i++) nv_write(3'(i), 8'h10 + 8'(i));
		nv_write(3'h7, 8'h7B);
		nv_key(1'b0);
		nv_write(3'h3, 8'hEE);
		for (int i = 3; i < 7; i++) nv_read(3'(i), 8'h10 + 8'(i));
		do_reset;
		check_val(unl, 1'b0);
		check_val({rdy, nerr}, 2'h2);
		nv_key(1'b1);
		nv_write(3'h4, 8'h00);
		do_reset;
		check_val({rdy, nerr}, 2'h3);
		$display("test store done");
		conclude;
	end
endmodule
